//--- rtl/spc_enable_latch.sv
// one clocked transparent enable latch fed from the shared enable bus
module spc_enable_latch #(
  parameter logic [3:0] CLEAR_VALUE = 4'h0,
  parameter logic CLEAR_WHEN_OPEN = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  spc_latch_if.store port
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // the latch is modelled as a flop tracking the bus each clock while open;
  // this costs one cycle of latency but keeps the design free of real latches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port.value <= CLEAR_VALUE;
    end else if (port.dev_rst && (CLEAR_WHEN_OPEN || !port.ctl)) begin
      port.value <= CLEAR_VALUE;  // R7 R10 R13
    end else if (port.ctl) begin
      port.value <= port.bus;  // R6 R9 R12 R15
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_latch_follows: assert property (@(posedge clk_i) disable iff (rst_i) // R15
    port.ctl && !port.dev_rst |=> port.value == $past(port.bus))
    else $error("open latch does not follow the shared bus");

  chk_latch_holds: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    $fell(port.ctl) && !port.dev_rst ##1 !port.ctl && !port.dev_rst [*2]
    |-> port.value == $past(port.bus, 3))
    else $error("closed latch lost the captured enables");

  chk_latch_clears: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    port.dev_rst && (CLEAR_WHEN_OPEN || !port.ctl) |=> port.value == CLEAR_VALUE)
    else $error("latch not cleared by device reset");

endmodule

//--- rtl/spc_top.sv
// serial port configuration: input select, threshold, loopback and enable latches
//
// Notes on behaviour
// R1 - selector high feeds primary input to recovery
// R2 - three-level setting picks amplitude detect threshold
// R3 - loopback routes each channel's transmit into receive
// R4 - loopback forces drivers one, ignores serial inputs
// R5 - open driver latch: bit high enables driver
// R6 - driver latch holds bus when control falls
// R7 - device reset clears driver latch, drivers off
// R8 - open power latch: bit high powers channel
// R9 - power latch stores bus when control falls
// R10 - device reset clears power latch, channels off
// R11 - open self-test latch: bit low selects self-test
// R12 - self-test latch stores bus when control falls
// R13 - reset while closed clears self-test everywhere
// R14 - device reset sampled on clock rising edge
// R15 - shared bus passes open latch, captured on close
// R16 - host keeps bus stable around control fall
// R17 - fixed parameter maps enable bits to targets
//
// The APB register port and the placing of the registers were chosen for this implementation.
module spc_top (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [1:0] TX_SERIAL_I,
  input wire logic [1:0] PRIMARY_SERIAL_IN_I,
  input wire logic [1:0] SECONDARY_SERIAL_IN_I,
  output logic [1:0] CLOCK_DATA_RECOVERY_O,
  output logic [3:0] SERIAL_DRIVER_OUT_O,
  output logic [3:0] DRV_ENABLE_O,
  output logic [1:0] RX_POWER_O,
  output logic [1:0] TX_SELFTEST_N_O,
  output logic [1:0] RX_SELFTEST_N_O,
  output logic [1:0] DETECT_THRESHOLD_O
);

  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  localparam int LATCH_COUNT_L = spc_pkg::LATCH_COUNT;  // latches fed by the shared bus
  logic loopback_on;                       // all-port loopback
  logic [1:0] rx_input_choose;             // bit 0 channel a, bit 1 channel b
  logic [1:0] detect_threshold_choose;     // three-level amplitude setting
  logic device_reset_n;                    // software image of the device reset
  logic dev_rst_seen;                      // reset as sampled on the clock
  logic [2:0] latch_ctl;                   // one control per latch
  logic [3:0] shared_enable_bus;           // bus feeding all three latches
  logic [3:0] latch_val [LATCH_COUNT_L];   // stored contents per latch
  logic wr_ctrl;                           // write strobe for the control word
  logic setup;                             // apb setup phase
  logic [31:0] next_rdata;                 // read data chosen at setup
  logic next_slverr;                       // unmapped address flag

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // zero wait states: read data and error are registered during setup
  // so they are already stable when the access phase samples them
  assign PREADY_O = 1'b1;
  assign setup = PSEL_I && !PENABLE_I;
  assign wr_ctrl = PSEL_I && PENABLE_I && PWRITE_I && (PADDR_I == spc_pkg::ADDR_CTRL);

  // read multiplexer, unmapped addresses read zero
  // a write to the status word reads back nothing and raises no error
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_slverr = 1'b0;
    case (PADDR_I)
      spc_pkg::ADDR_CTRL: begin
        next_rdata[spc_pkg::CTRL_LOOP_BIT] = loopback_on;
        next_rdata[spc_pkg::CTRL_CHOOSE_A_BIT] = rx_input_choose[0];
        next_rdata[spc_pkg::CTRL_CHOOSE_B_BIT] = rx_input_choose[1];
        next_rdata[spc_pkg::CTRL_THRESH_LSB +: 2] = detect_threshold_choose;
        next_rdata[spc_pkg::CTRL_DEV_RST_N_BIT] = device_reset_n;
        next_rdata[spc_pkg::CTRL_LATCH_CTL_LSB +: 3] = latch_ctl;
        next_rdata[spc_pkg::CTRL_ENABLE_BUS_LSB +: 4] = shared_enable_bus;
      end
      spc_pkg::ADDR_STATUS: begin
        next_rdata[spc_pkg::STAT_OE_LSB +: 4] = latch_val[spc_pkg::LATCH_OE];
        next_rdata[spc_pkg::STAT_RX_LSB +: 4] = latch_val[spc_pkg::LATCH_RX];
        next_rdata[spc_pkg::STAT_BIST_LSB +: 4] = latch_val[spc_pkg::LATCH_BIST];
      end
      default: begin
        next_slverr = 1'b1;  // no register here
      end
    endcase
  end

  // read data and error flop, captured at setup
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      PRDATA_O <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else if (setup) begin
      PRDATA_O <= PWRITE_I ? 32'h0000_0000 : next_rdata;
      PSLVERR_O <= next_slverr && !(PWRITE_I && PADDR_I == spc_pkg::ADDR_STATUS) ? next_slverr : 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // writes to the status word are ignored; it only reflects latch state
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      loopback_on <= spc_pkg::CTRL_LOOP_RST;
      rx_input_choose <= spc_pkg::CTRL_CHOOSE_RST;
      detect_threshold_choose <= spc_pkg::CTRL_THRESH_RST;
      device_reset_n <= spc_pkg::CTRL_DEV_RST_N_RST;
      latch_ctl <= spc_pkg::CTRL_LATCH_CTL_RST;
      shared_enable_bus <= spc_pkg::CTRL_ENABLE_BUS_RST;
    end else if (wr_ctrl) begin
      loopback_on <= PWDATA_I[spc_pkg::CTRL_LOOP_BIT];
      rx_input_choose <= {PWDATA_I[spc_pkg::CTRL_CHOOSE_B_BIT], PWDATA_I[spc_pkg::CTRL_CHOOSE_A_BIT]};
      detect_threshold_choose <= PWDATA_I[spc_pkg::CTRL_THRESH_LSB +: 2];
      device_reset_n <= PWDATA_I[spc_pkg::CTRL_DEV_RST_N_BIT];
      latch_ctl <= PWDATA_I[spc_pkg::CTRL_LATCH_CTL_LSB +: 3];
      shared_enable_bus <= PWDATA_I[spc_pkg::CTRL_ENABLE_BUS_LSB +: 4];
    end
  end

  // ----------------------------------------------------------------
  // device reset sampling
  // ----------------------------------------------------------------
  // one clock edge samples the reset level; the latches act on the sample
  // trade-off: this adds one cycle before the latches clear, but keeps the
  // clear decision off the raw register output
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      dev_rst_seen <= 1'b0;
    end else begin
      dev_rst_seen <= !device_reset_n;  // R14
    end
  end

  // ----------------------------------------------------------------
  // the three enable latches
  // ----------------------------------------------------------------
  // the self-test latch ignores a device reset while it is open, so a host
  // can hold a test setting through reset; the other two clear regardless
  spc_latch_if lif [LATCH_COUNT_L] ();

  generate
    for (genvar g = 0; g < LATCH_COUNT_L; g++) begin : g_latch
      assign lif[g].ctl = latch_ctl[g];
      assign lif[g].bus = shared_enable_bus;
      assign lif[g].dev_rst = dev_rst_seen;
      assign latch_val[g] = lif[g].value;
      spc_enable_latch #(
        .CLEAR_VALUE(spc_pkg::LATCH_CLEAR_VALUES[4*g +: 4]),
        .CLEAR_WHEN_OPEN(spc_pkg::LATCH_CLEAR_WHEN_OPEN[g])
      ) u_latch (
        .clk_i(SYS_CLK_I),
        .rst_i(SYS_RST_I),
        .port(lif[g].store)
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // enable bit assignment to drivers and channels
  // ----------------------------------------------------------------
  // the mapping tables live in the package so a board can reorder bits
  generate
    for (genvar d = 0; d < 4; d++) begin : g_drv
      // driver enable, high enables and low powers down
      assign DRV_ENABLE_O[d] = latch_val[spc_pkg::LATCH_OE][spc_pkg::DRV_MAP[2*d +: 2]];  // R17
    end
    for (genvar c = 0; c < 2; c++) begin : g_chan
      // receive power, high active and low power saving
      assign RX_POWER_O[c] = latch_val[spc_pkg::LATCH_RX][spc_pkg::RX_MAP[2*c +: 2]];  // R8
      // self-test, low generates or checks the test pattern
      assign TX_SELFTEST_N_O[c] = latch_val[spc_pkg::LATCH_BIST][spc_pkg::BIST_MAP[2*c +: 2]];  // R11
      assign RX_SELFTEST_N_O[c] = latch_val[spc_pkg::LATCH_BIST][spc_pkg::BIST_MAP[2*c+4 +: 2]];  // R11
    end
  endgenerate

  // ----------------------------------------------------------------
  // receive input selection and loopback
  // ----------------------------------------------------------------
  // loopback takes priority; external inputs are then not looked at
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      CLOCK_DATA_RECOVERY_O <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (loopback_on) begin
          CLOCK_DATA_RECOVERY_O[c] <= TX_SERIAL_I[c];  // R3
        end else if (rx_input_choose[c]) begin
          CLOCK_DATA_RECOVERY_O[c] <= PRIMARY_SERIAL_IN_I[c];  // R1
        end else begin
          CLOCK_DATA_RECOVERY_O[c] <= SECONDARY_SERIAL_IN_I[c];  // R1
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // serial drivers
  // ----------------------------------------------------------------
  // drivers 0,1 belong to channel a and 2,3 to channel b; a powered down
  // driver shows zero, loopback overrides with a steady one
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      SERIAL_DRIVER_OUT_O <= 4'h0;
    end else begin
      for (int d = 0; d < 4; d++) begin
        if (loopback_on) begin
          SERIAL_DRIVER_OUT_O[d] <= 1'b1;  // R4
        end else begin
          SERIAL_DRIVER_OUT_O[d] <= DRV_ENABLE_O[d] && TX_SERIAL_I[d/2];  // R5
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // amplitude threshold select
  // ----------------------------------------------------------------
  // the unused fourth code falls back to the middle trip point
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      DETECT_THRESHOLD_O <= spc_pkg::THRESH_MID;
    end else begin
      case (detect_threshold_choose)
        spc_pkg::THRESH_LOW: DETECT_THRESHOLD_O <= spc_pkg::THRESH_LOW;  // R2
        spc_pkg::THRESH_HIGH: DETECT_THRESHOLD_O <= spc_pkg::THRESH_HIGH;  // R2
        default: DETECT_THRESHOLD_O <= spc_pkg::THRESH_MID;  // R2
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // latch outputs trail a control register change by one edge, and the
  // serial paths trail their inputs by one edge, so checks look one cycle back

  chk_input_select: assert property (!loopback_on |=> // R1
    CLOCK_DATA_RECOVERY_O == {
      ($past(rx_input_choose[1]) ? $past(PRIMARY_SERIAL_IN_I[1]) : $past(SECONDARY_SERIAL_IN_I[1])),
      ($past(rx_input_choose[0]) ? $past(PRIMARY_SERIAL_IN_I[0]) : $past(SECONDARY_SERIAL_IN_I[0]))})
    else $error("recovery input does not follow the selector");

  chk_thresh_pick: assert property ($stable(detect_threshold_choose) && detect_threshold_choose != 2'h3 // R2
    |=> DETECT_THRESHOLD_O == $past(detect_threshold_choose))
    else $error("threshold select not applied");

  chk_loop_route: assert property (loopback_on |=> CLOCK_DATA_RECOVERY_O == $past(TX_SERIAL_I)) // R3
    else $error("loopback does not route transmit into receive");

  chk_loop_ones: assert property (loopback_on |=> SERIAL_DRIVER_OUT_O == 4'hF) // R4
    else $error("drivers not forced to one in loopback");

  chk_drv_off: assert property (!loopback_on && DRV_ENABLE_O == 4'h0 // R5
    |=> SERIAL_DRIVER_OUT_O == 4'h0)
    else $error("powered down driver is not quiet");

  chk_drv_open: assert property (latch_ctl[spc_pkg::LATCH_OE] && !dev_rst_seen // R5
    ##1 latch_ctl[spc_pkg::LATCH_OE] && !dev_rst_seen
    |-> DRV_ENABLE_O == {$past(shared_enable_bus[spc_pkg::DRV_MAP[7:6]]),
                         $past(shared_enable_bus[spc_pkg::DRV_MAP[5:4]]),
                         $past(shared_enable_bus[spc_pkg::DRV_MAP[3:2]]),
                         $past(shared_enable_bus[spc_pkg::DRV_MAP[1:0]])})
    else $error("open driver latch not transparent");

  chk_drv_reset: assert property ($fell(device_reset_n) |-> ##2 DRV_ENABLE_O == 4'h0) // R7
    else $error("device reset did not disable the drivers");

  chk_rx_reset: assert property ($fell(device_reset_n) |-> ##2 RX_POWER_O == 2'h0) // R10
    else $error("device reset did not disable the receive channels");

  chk_bist_reset: assert property ($fell(device_reset_n) && latch_ctl == 3'h0 ##1 latch_ctl == 3'h0 // R13
    |-> ##1 {TX_SELFTEST_N_O, RX_SELFTEST_N_O} == 4'hF)
    else $error("device reset did not end self-test");

  chk_rx_capture: assert property ($fell(latch_ctl[spc_pkg::LATCH_RX]) && !dev_rst_seen // R9
    && $stable(shared_enable_bus) ##1 !dev_rst_seen
    |=> RX_POWER_O == {$past(shared_enable_bus[spc_pkg::RX_MAP[3:2]], 2),
                       $past(shared_enable_bus[spc_pkg::RX_MAP[1:0]], 2)})
    else $error("receive power latch did not capture the bus");

  chk_bist_capture: assert property ($fell(latch_ctl[spc_pkg::LATCH_BIST]) && !dev_rst_seen // R12
    && $stable(shared_enable_bus) |=> !dev_rst_seen |-> latch_val[spc_pkg::LATCH_BIST] == $past(shared_enable_bus, 2))
    else $error("self-test latch did not capture the bus");

  // main scenarios the bench is expected to reach
  cov_loopback: cover property (loopback_on ##1 loopback_on);
  cov_drv_capture: cover property ($fell(latch_ctl[spc_pkg::LATCH_OE]) ##1 DRV_ENABLE_O != 4'h0);
  cov_selftest: cover property (TX_SELFTEST_N_O != 2'h3);
  cov_dev_reset: cover property ($fell(device_reset_n));
  cov_rx_capture: cover property ($fell(latch_ctl[spc_pkg::LATCH_RX]));

endmodule

//--- shared/spc_latch_if.sv
// carrier between the top and one enable latch
interface spc_latch_if;
  logic ctl;          // latch control, high means transparent
  logic [3:0] bus;    // shared enable bus
  logic dev_rst;      // device reset sampled low
  logic [3:0] value;  // stored enables

  modport owner (output ctl, output bus, output dev_rst, input value);
  modport store (input ctl, input bus, input dev_rst, output value);
endinterface

//--- shared/spc_pkg.sv
// constants shared by the serial port configuration block
package spc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the apb bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;    // configuration, latch controls, shared enables
  localparam logic [7:0] ADDR_STATUS = 8'h04;  // stored latch contents, read only

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_LOOP_BIT = 0;             // loopback_on
  localparam int CTRL_CHOOSE_A_BIT = 1;         // rx_input_choose_a
  localparam int CTRL_CHOOSE_B_BIT = 2;         // rx_input_choose_b
  localparam int CTRL_THRESH_LSB = 4;           // detect_threshold_choose, two bits
  localparam int CTRL_DEV_RST_N_BIT = 8;        // device_reset_n, active low
  localparam int CTRL_LATCH_CTL_LSB = 16;       // three latch controls
  localparam int CTRL_ENABLE_BUS_LSB = 24;      // shared_enable_bus, four bits

  // ----------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------
  localparam int STAT_OE_LSB = 0;               // driver enable latch
  localparam int STAT_RX_LSB = 4;               // receive power latch
  localparam int STAT_BIST_LSB = 8;             // self-test latch

  // ----------------------------------------------------------------
  // reset values of the control fields
  // ----------------------------------------------------------------
  localparam logic CTRL_LOOP_RST = 1'b0;
  localparam logic [1:0] CTRL_CHOOSE_RST = 2'h3;     // primary inputs selected
  localparam logic [1:0] CTRL_THRESH_RST = 2'h1;     // middle trip point
  localparam logic CTRL_DEV_RST_N_RST = 1'b1;        // device out of reset
  localparam logic [2:0] CTRL_LATCH_CTL_RST = 3'h0;  // all latches closed
  localparam logic [3:0] CTRL_ENABLE_BUS_RST = 4'h0;

  // ----------------------------------------------------------------
  // latch indices and their cleared contents
  // ----------------------------------------------------------------
  localparam int LATCH_OE = 0;                  // serial driver output enables
  localparam int LATCH_RX = 1;                  // receive channel power enables
  localparam int LATCH_BIST = 2;                // self-test enables, low means self-test
  localparam int LATCH_COUNT = 3;
  localparam logic [11:0] LATCH_CLEAR_VALUES = {4'hF, 4'h0, 4'h0};  // bist cleared to normal mode
  localparam logic [2:0] LATCH_CLEAR_WHEN_OPEN = 3'h3;              // bist only clears while closed

  // ----------------------------------------------------------------
  // three-level amplitude threshold codes
  // ----------------------------------------------------------------
  localparam logic [1:0] THRESH_LOW = 2'h0;
  localparam logic [1:0] THRESH_MID = 2'h1;
  localparam logic [1:0] THRESH_HIGH = 2'h2;

  // ----------------------------------------------------------------
  // shared enable bit assignment, two bits per target naming a bus bit
  // ----------------------------------------------------------------
  localparam logic [7:0] DRV_MAP = {2'h3, 2'h2, 2'h1, 2'h0};   // drivers a1, a2, b1, b2 from bit 0 up
  localparam logic [3:0] RX_MAP = {2'h2, 2'h0};                // receive channel a, b
  localparam logic [7:0] BIST_MAP = {2'h3, 2'h2, 2'h1, 2'h0};  // tx a, tx b, rx a, rx b

endpackage

//--- verif/spc_serial_src.sv
// host-side model that feeds the serial transmit and receive data pins
module spc_serial_src (
  input wire logic clk_i,
  output logic [1:0] tx_o,
  output logic [1:0] prim_o,
  output logic [1:0] sec_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // pattern counter
  // ----------------------------------------------------------------
  logic [2:0] cnt = 3'h0;  // free-running, so every stream keeps moving
  // advance just after each rising edge, as a real host would
  always @(posedge clk_i) begin
    cnt <= cnt + 3'h1;
  end
  // primary and secondary always differ; transmit matches one of them in half the counts
  assign prim_o = cnt[1:0];
  assign sec_o = ~cnt[1:0];
  assign tx_o = {cnt[2], ~cnt[1]};
endmodule

//--- verif/tb.sv
// self-checking bench for the serial port configuration block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, cur;  // cur shadows the control word
  logic pready, pslverr, err;
  logic [1:0] tx, prim, sec, p_tx, p_prim, p_sec, rec, rxp, txn, rxn, thr;
  logic [3:0] drv, drv_en, exp_en;
  logic [2:0] sel_tab [4] = '{3'h6, 3'h0, 3'h2, 3'h7};  // {choose, loopback}
  int miscompares = 0;
  int n_checks = 0;
  initial begin
    forever #2.5 clk = ~clk;
  end
  spc_top dut_u (.SYS_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .TX_SERIAL_I(tx), .PRIMARY_SERIAL_IN_I(prim), .SECONDARY_SERIAL_IN_I(sec),
    .CLOCK_DATA_RECOVERY_O(rec), .SERIAL_DRIVER_OUT_O(drv), .DRV_ENABLE_O(drv_en), .RX_POWER_O(rxp),
    .TX_SELFTEST_N_O(txn), .RX_SELFTEST_N_O(rxn), .DETECT_THRESHOLD_O(thr));
  spc_serial_src host_u (.clk_i(clk), .tx_o(tx), .prim_o(prim), .sec_o(sec));
  // keep what the design sampled at each edge, for the one-cycle serial paths
  always @(posedge clk) begin
    p_tx <= tx;
    p_prim <= prim;
    p_sec <= sec;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // one apb transfer; pready is polled, though this slave never adds wait states
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      miscompares++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // latches answer one edge after the write edge, a device reset clears them two edges after
  task automatic wr_ctrl(input logic [31:0] v);
    cur = v;
    xfer(1'b1, spc_pkg::ADDR_CTRL, v);
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  function automatic logic [31:0] mk(input logic [3:0] bus, input logic [2:0] lat, input logic rn,
    input logic [1:0] th, input logic [1:0] ch, input logic lp);
    return (32'(bus) << spc_pkg::CTRL_ENABLE_BUS_LSB) | (32'(lat) << spc_pkg::CTRL_LATCH_CTL_LSB)
      | (32'(rn) << spc_pkg::CTRL_DEV_RST_N_BIT) | (32'(th) << spc_pkg::CTRL_THRESH_LSB)
      | (32'(ch) << spc_pkg::CTRL_CHOOSE_A_BIT) | (32'(lp) << spc_pkg::CTRL_LOOP_BIT);
  endfunction
  // compare recovery feed and drivers against the stream seen one edge earlier
  task automatic serial(input int n);
    logic [1:0] c;
    logic [3:0] o;
    logic lp;
    repeat (n) begin
      @(negedge clk);
      lp = cur[spc_pkg::CTRL_LOOP_BIT];
      for (int k = 0; k < 2; k++) c[k] = lp ? p_tx[k] : (cur[1 + k] ? p_prim[k] : p_sec[k]);
      for (int d = 0; d < 4; d++) o[d] = lp | (exp_en[d] & p_tx[d / 2]);
      chk(32'(rec), 32'(c));
      chk(32'(drv), 32'(o));
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    exp_en = 4'h0;
    cur = 32'h0000_0116;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    xfer(1'b0, spc_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h0000_0116);
    xfer(1'b0, spc_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0000_0F00);
    chk(32'({drv_en, rxp, txn, rxn, thr}), 32'({4'h0, 2'h0, 2'h3, 2'h3, 2'h1}));
    xfer(1'b0, 8'h08, 32'h0);
    chk(32'(err), 32'h1);
    xfer(1'b1, spc_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
    xfer(1'b1, 8'h0C, 32'h0);
    xfer(1'b0, spc_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0000_0F00);
    $display("test reset and map done");
    // every input choice, loopback, and every threshold code
    for (int m = 0; m < 4; m++) begin
      wr_ctrl(mk(4'h0, 3'h0, 1'b1, 2'(m), sel_tab[m][2:1], sel_tab[m][0]));
      serial(6);
      chk(32'(thr), (m == 3) ? 32'h1 : 32'(m));
    end
    $display("test select loopback threshold done");
    wr_ctrl(mk(4'hA, 3'h1, 1'b1, 2'h1, 2'h3, 1'b0));
    exp_en = 4'hA;
    serial(4);
    chk(32'(drv_en), 32'hA);
    // bus held while the control falls, then changed behind the closed latch
    wr_ctrl(mk(4'hA, 3'h0, 1'b1, 2'h1, 2'h3, 1'b0));
    wr_ctrl(mk(4'h5, 3'h0, 1'b1, 2'h1, 2'h3, 1'b0));
    serial(4);
    chk(32'(drv_en), 32'hA);
    wr_ctrl(mk(4'h4, 3'h2, 1'b1, 2'h1, 2'h3, 1'b0));
    chk(32'(rxp), 32'h2);
    wr_ctrl(mk(4'h4, 3'h0, 1'b1, 2'h1, 2'h3, 1'b0));
    wr_ctrl(mk(4'h1, 3'h0, 1'b1, 2'h1, 2'h3, 1'b0));
    chk(32'({rxp, drv_en}), 32'h2A);
    wr_ctrl(mk(4'h6, 3'h4, 1'b1, 2'h1, 2'h3, 1'b0));
    chk(32'({txn, rxn}), 32'h9);
    wr_ctrl(mk(4'h6, 3'h0, 1'b1, 2'h1, 2'h3, 1'b0));
    wr_ctrl(mk(4'hF, 3'h0, 1'b1, 2'h1, 2'h3, 1'b0));
    chk(32'({txn, rxn}), 32'h9);
    xfer(1'b0, spc_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0000_064A);
    $display("test latches done");
    // device reset with every latch closed clears all three
    wr_ctrl(mk(4'hF, 3'h0, 1'b0, 2'h1, 2'h3, 1'b0));
    chk(32'({drv_en, rxp, txn, rxn}), 32'h0F);
    wr_ctrl(mk(4'h0, 3'h0, 1'b1, 2'h1, 2'h3, 1'b0));
    // an open self-test latch keeps following the bus through device reset
    wr_ctrl(mk(4'h0, 3'h4, 1'b0, 2'h1, 2'h3, 1'b0));
    chk(32'({txn, rxn}), 32'h0);
    $display("test device reset done");
    test_done();
  end
endmodule
